// File: verilog/lpmc_pkg.sv
// Purpose: constants, types and register map of the low-power mode controller
// Assumes: 32-bit AHB-Lite register access, one aligned word per register
// Notes: all addresses are full byte addresses
package lpmc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] ADDR_PLL_CTRL = 32'h1000_0010;
  localparam logic [31:0] ADDR_LOW_POWER_CONTROL = 32'h1000_0004;
  localparam logic [31:0] ADDR_MODULE_CLOCK_GATE = 32'h1000_0020;
  localparam logic [31:0] ADDR_SLEEP_CONTROL = 32'h1000_0024;
  localparam logic [31:0] ADDR_MODE_STATUS = 32'h1000_0028;
  localparam logic [31:0] RST_LOW_POWER_CONTROL = 32'h0000_00f8;
  localparam logic [31:0] RST_MODULE_CLOCK_GATE = 32'h0000_0000;
  localparam logic [31:0] RST_SLEEP_CONTROL = 32'h0000_1500;
  localparam logic [7:0] RST_LOCK_WAIT = 8'h11;
  // ****************************************
  // field layout
  // ****************************************
  localparam int KIND_LSB = 0;
  localparam int DOZE_BIT = 2;
  localparam int DUTY_LSB = 3;
  localparam int OSC_KEEP_BIT = 4;
  localparam int UDC_SUSP_BIT = 6;
  localparam int UHC_SUSP_BIT = 7;
  localparam int OSC_WAIT_LSB = 8;
  localparam int LOCK_LSB = 0;
  localparam int GATE_BITS = 16;
  localparam logic [4:0] DUTY_FULL = 5'h1f;
  localparam logic [4:0] SLOT_LAST = 5'h1e;
  localparam logic [4:0] SLOT_FIRST = 5'h00;
  localparam logic [1:0] KIND_IDLE = 2'h0;
  localparam logic [1:0] KIND_SLEEP = 2'h1;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] LOCK_ONE = 8'h01;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_WAIT_CORE,
    MODE_IDLE,
    MODE_SLEEP,
    MODE_PLL_LOCK
  } lpmc_mode_t;

  typedef struct packed {
    logic [4:0] duty;
    logic doze;
    logic [1:0] sleep_kind_select;
  } lpmc_lpc_t;

  typedef struct packed {
    logic core;
    logic basic;
    logic pll;
    logic osc;
    logic [GATE_BITS-1:0] periph;
  } lpmc_clk_en_t;
endpackage : lpmc_pkg

// File: verilog/lpmc_ctrl.sv
// Purpose: low-power mode controller: doze, idle, sleep, per-module clock gates
// Assumes: core clock gate cells outside latch these enables on the low phase
// Notes: single hclk domain, registers on AHB-Lite, zero wait states
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - normal mode runs basics, peripherals individually gateable
// - doze bit set puts core into doze
// - doze ends on reset, interrupt, clear
// - other clocks run continuously during doze
// - interrupt-cancelled doze clears doze bit itself
// - duty field gives n/31 core clock
// - idle stops core, keeps basic clocks
// - any interrupt leaves idle, core resumes
// - sleep stops all clocks and pll
// - sleep exits only on reset or interrupt
// - sleep exit waits pll lock count first
// - gate bit stops module clock until cleared
// - sleep kind selects idle or sleep
// - reset loads control register 0x000000f8
// - control bits 31:8 read zero, ignore writes
// - registers accept whole 32-bit words only
// - lock wait counts realtime ticks, bits 7:0
// - osc keep bit holds oscillator in sleep
module lpmc_ctrl #(
  parameter int GATES = lpmc_pkg::GATE_BITS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic cpu_sleep_exec,
  input wire logic cpu_idle_ack,
  input wire logic irq_pending,
  input wire logic realtime_tick,
  output lpmc_pkg::lpmc_clk_en_t clk_en,
  output logic uhc_suspend,
  output logic udc_suspend
);
  import lpmc_pkg::*;

  typedef struct packed {
    lpmc_mode_t mode;
    logic go_sleep;
    lpmc_lpc_t lpc;
    logic [GATE_BITS-1:0] gate_register;
    logic [7:0] osc_wait;
    logic uhc_susp;
    logic udc_susp;
    logic osc_keep_in_sleep;
    logic [7:0] lock_wait_count;
    logic [7:0] lock_cnt;
    logic [4:0] slot;
    logic tick_prev;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    lpmc_clk_en_t en;
  } lpmc_state_t;

  lpmc_state_t st_q;
  lpmc_state_t st_d;
  logic take;
  logic tick_rise;

  // ****************************************
  // register read mux
  // ****************************************
  function automatic logic [31:0] read_word(input lpmc_state_t s, input logic [31:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      ADDR_LOW_POWER_CONTROL: r[DUTY_LSB+4:KIND_LSB] = s.lpc;
      ADDR_MODULE_CLOCK_GATE: r[GATE_BITS-1:0] = s.gate_register;
      ADDR_SLEEP_CONTROL: begin
        r[OSC_WAIT_LSB+7:OSC_WAIT_LSB] = s.osc_wait;
        r[UHC_SUSP_BIT] = s.uhc_susp;
        r[UDC_SUSP_BIT] = s.udc_susp;
        r[OSC_KEEP_BIT] = s.osc_keep_in_sleep;
      end
      ADDR_PLL_CTRL: r[LOCK_LSB+7:LOCK_LSB] = s.lock_wait_count;
      ADDR_MODE_STATUS: r[2:0] = s.mode;
      default: r = '0;
    endcase
    return r;
  endfunction : read_word

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.tick_prev = realtime_tick;
    tick_rise = realtime_tick & ~st_q.tick_prev;
    take = hsel & htrans[1] & hready;
    // narrow writes are dropped: only whole words reach the registers
    st_d.wr_pend = take & hwrite & (hsize == HSIZE_WORD);
    if (take) begin
      st_d.wr_addr = haddr;
      st_d.rdata = hwrite ? 32'h0000_0000 : read_word(st_q, haddr);
    end

    case (st_q.mode)
      MODE_NORMAL: begin
        if (st_q.lpc.doze && irq_pending) begin
          st_d.lpc.doze = 1'b0;
        end
        if (cpu_sleep_exec) begin
          // reserved kinds leave the core running
          if (st_q.lpc.sleep_kind_select == KIND_IDLE ||
              st_q.lpc.sleep_kind_select == KIND_SLEEP) begin
            st_d.lpc.doze = 1'b0;
            st_d.go_sleep = (st_q.lpc.sleep_kind_select == KIND_SLEEP);
            st_d.mode = MODE_WAIT_CORE;
          end
        end
      end
      MODE_WAIT_CORE: begin
        if (cpu_idle_ack) begin
          st_d.mode = st_q.go_sleep ? MODE_SLEEP : MODE_IDLE;
        end
      end
      MODE_IDLE: begin
        if (irq_pending) begin
          st_d.mode = MODE_NORMAL;
        end
      end
      MODE_SLEEP: begin
        if (irq_pending) begin
          st_d.lock_cnt = '0;
          st_d.mode = MODE_PLL_LOCK;
        end
      end
      MODE_PLL_LOCK: begin
        if (st_q.lock_cnt >= st_q.lock_wait_count) begin
          st_d.mode = MODE_NORMAL;
        end else if (tick_rise) begin
          st_d.lock_cnt = st_q.lock_cnt + LOCK_ONE;
        end
      end
      default: st_d.mode = MODE_NORMAL;
    endcase

    // software write lands after the hardware clear, so a new doze request wins
    if (st_q.wr_pend) begin
      case (st_q.wr_addr)
        ADDR_LOW_POWER_CONTROL: st_d.lpc = hwdata[DUTY_LSB+4:KIND_LSB];
        ADDR_MODULE_CLOCK_GATE: st_d.gate_register = hwdata[GATE_BITS-1:0];
        ADDR_SLEEP_CONTROL: begin
          st_d.osc_wait = hwdata[OSC_WAIT_LSB+7:OSC_WAIT_LSB];
          st_d.uhc_susp = hwdata[UHC_SUSP_BIT];
          st_d.udc_susp = hwdata[UDC_SUSP_BIT];
          st_d.osc_keep_in_sleep = hwdata[OSC_KEEP_BIT];
        end
        ADDR_PLL_CTRL: st_d.lock_wait_count = hwdata[LOCK_LSB+7:LOCK_LSB];
        default: st_d.lock_cnt = st_d.lock_cnt;
      endcase
    end

    // doze slot counter: 31 slots, core on while slot is below duty
    if (st_d.mode == MODE_NORMAL && st_d.lpc.doze) begin
      st_d.slot = (st_q.slot == SLOT_LAST) ? SLOT_FIRST : st_q.slot + 5'h01;
    end else begin
      st_d.slot = SLOT_FIRST;
    end

    // enables are registered so each gate edge sits on a whole period
    case (st_d.mode)
      MODE_NORMAL, MODE_WAIT_CORE: begin
        st_d.en.core = st_d.lpc.doze ? (st_d.slot < st_d.lpc.duty) : 1'b1;
        st_d.en.basic = 1'b1;
        st_d.en.pll = 1'b1;
        st_d.en.osc = 1'b1;
        st_d.en.periph = ~st_d.gate_register;
      end
      MODE_IDLE: begin
        st_d.en.core = 1'b0;
        st_d.en.basic = 1'b1;
        st_d.en.pll = 1'b1;
        st_d.en.osc = 1'b1;
        st_d.en.periph = ~st_d.gate_register;
      end
      MODE_SLEEP: begin
        st_d.en.core = 1'b0;
        st_d.en.basic = 1'b0;
        st_d.en.pll = 1'b0;
        st_d.en.osc = st_d.osc_keep_in_sleep;
        st_d.en.periph = '0;
      end
      default: begin
        // pll relocking: oscillator and pll up, every gated clock still held
        st_d.en.core = 1'b0;
        st_d.en.basic = 1'b0;
        st_d.en.pll = 1'b1;
        st_d.en.osc = 1'b1;
        st_d.en.periph = '0;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
      st_q.mode <= MODE_NORMAL;
      st_q.lpc <= RST_LOW_POWER_CONTROL[DUTY_LSB+4:KIND_LSB];
      st_q.gate_register <= RST_MODULE_CLOCK_GATE[GATE_BITS-1:0];
      st_q.osc_wait <= RST_SLEEP_CONTROL[OSC_WAIT_LSB+7:OSC_WAIT_LSB];
      st_q.uhc_susp <= RST_SLEEP_CONTROL[UHC_SUSP_BIT];
      st_q.udc_susp <= RST_SLEEP_CONTROL[UDC_SUSP_BIT];
      st_q.osc_keep_in_sleep <= RST_SLEEP_CONTROL[OSC_KEEP_BIT];
      st_q.lock_wait_count <= RST_LOCK_WAIT;
      st_q.en.core <= 1'b1;
      st_q.en.basic <= 1'b1;
      st_q.en.pll <= 1'b1;
      st_q.en.osc <= 1'b1;
      st_q.en.periph <= '1;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_q.rdata;
  assign clk_en = st_q.en;
  assign uhc_suspend = st_q.uhc_susp;
  assign udc_suspend = st_q.udc_susp;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);

  sequence s_wake_req;
    st_q.mode == MODE_SLEEP && irq_pending;
  endsequence
  sequence s_relock;
    st_q.mode == MODE_PLL_LOCK && !clk_en.core && !clk_en.basic;
  endsequence

  a_upper_reads_zero: assert property (
    take && !hwrite && haddr == ADDR_LOW_POWER_CONTROL |=> hrdata[31:8] == 24'h000000)
    else $error("control register upper bits not zero");
  a_narrow_write_drop: assert property (
    take && hwrite && hsize != HSIZE_WORD |=> !st_q.wr_pend)
    else $error("narrow write accepted");
  a_duty_full_on: assert property (
    st_q.mode == MODE_NORMAL && st_q.lpc.doze && st_q.lpc.duty == DUTY_FULL
    && !irq_pending && !st_q.wr_pend && !cpu_sleep_exec |=> clk_en.core)
    else $error("full duty gated core clock");
  a_duty_zero_off: assert property (
    st_q.mode == MODE_NORMAL && st_q.lpc.doze && st_q.lpc.duty == 5'h00
    && !irq_pending && !st_q.wr_pend && !cpu_sleep_exec |=> !clk_en.core)
    else $error("zero duty passed core clock");
  a_doze_irq_clear: assert property (
    st_q.mode == MODE_NORMAL && st_q.lpc.doze && irq_pending && !st_q.wr_pend
    |=> !st_q.lpc.doze ##0 clk_en.core)
    else $error("doze not cancelled by interrupt");
  a_doze_others_run: assert property (
    st_q.mode == MODE_NORMAL && st_q.lpc.doze |-> clk_en.basic && clk_en.pll)
    else $error("basic clocks throttled in doze");
  a_idle_basic_on: assert property (
    st_q.mode == MODE_IDLE |-> !clk_en.core && clk_en.basic)
    else $error("idle clock enables wrong");
  a_idle_irq_exit: assert property (
    st_q.mode == MODE_IDLE && irq_pending |=> st_q.mode == MODE_NORMAL && clk_en.core)
    else $error("interrupt did not leave idle");
  a_sleep_all_off: assert property (
    st_q.mode == MODE_SLEEP |-> !clk_en.core && !clk_en.basic && !clk_en.pll
    && clk_en.periph == '0 && clk_en.osc == st_q.osc_keep_in_sleep)
    else $error("clock running in sleep");
  a_sleep_holds: assert property (
    st_q.mode == MODE_SLEEP && !irq_pending |=> st_q.mode == MODE_SLEEP)
    else $error("sleep left without interrupt");
  a_lock_wait_held: assert property (
    s_wake_req ##1 s_relock ##0 (st_q.lock_cnt < st_q.lock_wait_count)
    |=> st_q.mode == MODE_PLL_LOCK)
    else $error("clocks released before pll lock");
  a_gate_stops_module: assert property (
    st_q.mode == MODE_NORMAL && !st_q.wr_pend
    |=> clk_en.periph == ~$past(st_q.gate_register))
    else $error("module gate not applied");
  a_wait_core_ack: assert property (
    st_q.mode == MODE_WAIT_CORE && !cpu_idle_ack |=> st_q.mode == MODE_WAIT_CORE)
    else $error("mode entered before core idle");
endmodule : lpmc_ctrl
`default_nettype wire

// File: tb/lpmc_core_model.sv
// Purpose: cpu core stand-in for the sleep handshake, plus the realtime tick
// Assumes: the bench holds req high until it raises the wake interrupt
// Notes: the tick runs free, as the rtc keeps running in every mode
`timescale 1ns/1ps
`default_nettype none
module lpmc_core_model (
  input wire logic hclk,
  input wire logic req,
  input wire logic [3:0] dly,
  output logic cpu_sleep_exec,
  output logic cpu_idle_ack,
  output logic realtime_tick
);
  int n = 0;
  int t = 0;
  logic req_q = 1'b0;
  initial begin
    cpu_sleep_exec = 1'b0;
    cpu_idle_ack = 1'b0;
    realtime_tick = 1'b0;
  end
  always @(posedge hclk) begin
    req_q <= req;
    n <= (req && req_q) ? n + 1 : 0;
    cpu_sleep_exec <= req && !req_q;
    cpu_idle_ack <= req && req_q && n >= dly;
    t <= t + 1;
    realtime_tick <= t[2];
  end
endmodule : lpmc_core_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the low-power mode controller
// Assumes: one slave, so hready is the slave's own hreadyout
// Notes: lock count cut to 3 ticks to keep sleep exits short
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lpmc_pkg::*;
  logic hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, irq_pending, req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] dly;
  logic cpu_sleep_exec, cpu_idle_ack, realtime_tick, uhc_suspend, udc_suspend;
  lpmc_clk_en_t clk_en;
  int miscompares = 0;
  int n_checks = 0;
  int lpc, gate, cnt, p;
  assign hready = hreadyout;
  lpmc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cpu_sleep_exec(cpu_sleep_exec),
    .cpu_idle_ack(cpu_idle_ack), .irq_pending(irq_pending), .realtime_tick(realtime_tick),
    .clk_en(clk_en), .uhc_suspend(uhc_suspend), .udc_suspend(udc_suspend));
  lpmc_core_model core (.hclk(hclk), .req(req), .dly(dly), .cpu_sleep_exec(cpu_sleep_exec),
    .cpu_idle_ack(cpu_idle_ack), .realtime_tick(realtime_tick));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [2:0] sz, input logic [31:0] a,
                      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, HSIZE_WORD, a, d);
  endtask : wr
  task automatic rdck(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, HSIZE_WORD, a, 32'h0);
    chk(rd, exp);
  endtask : rdck
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    summarize();
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, irq_pending, req} = '0;
    {haddr, hwdata} = '0;
    ce = 1'b1;
    hsize = HSIZE_WORD;
    dly = 4'h3;
    void'($urandom(32'h5ca8));
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({12'h0, clk_en}, 32'h000f_ffff);
    rdck(ADDR_LOW_POWER_CONTROL, 32'hf8);
    rdck(ADDR_SLEEP_CONTROL, 32'h1500);
    wr(ADDR_LOW_POWER_CONTROL, 32'hffff_ff01);
    rdck(ADDR_LOW_POWER_CONTROL, 32'h01);
    rdck(32'h1000_0100, 32'h0);
    gate = $urandom & 32'hffff;
    rdck(ADDR_MODULE_CLOCK_GATE, 32'h0);
    wr(ADDR_MODULE_CLOCK_GATE, gate);
    xfer(1'b1, 3'h0, ADDR_MODULE_CLOCK_GATE, 32'h0);
    rdck(ADDR_MODULE_CLOCK_GATE, gate);
    chk({12'h0, clk_en}, {12'h0, 4'hf, 16'(~gate)});
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      lpc = (i == 0) ? 0 : (i == 1) ? 1 + $urandom % 30 : 31;
      wr(ADDR_LOW_POWER_CONTROL, (lpc << 3) | 4);
      repeat (2) @(posedge hclk);
      cnt = 0;
      repeat (31) begin
        @(posedge hclk);
        cnt += (clk_en.core === 1'b1);
      end
      chk(cnt, lpc);
      chk({13'h0, clk_en[18:0]}, {13'h0, 3'h7, 16'(~gate)});
      if (i == 0) begin
        irq_pending <= 1'b1;
        @(posedge hclk);
        irq_pending <= 1'b0;
      end else begin
        wr(ADDR_LOW_POWER_CONTROL, lpc << 3);
      end
      repeat (3) @(posedge hclk);
      chk(clk_en.core, 1'b1);
      rdck(ADDR_LOW_POWER_CONTROL, lpc << 3);
    end
    $display("test doze done");
    wr(ADDR_PLL_CTRL, 32'h3);
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_SLEEP_CONTROL, (k == 2) ? 32'h15d0 : 32'h1500);
      wr(ADDR_LOW_POWER_CONTROL, 32'hf8 | (k > 0));
      dly <= 4'(3 + $urandom % 6);
      req <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(clk_en.core, 1'b1);
      while (cpu_idle_ack !== 1'b1) @(posedge hclk);
      repeat (2) @(posedge hclk);
      chk({12'h0, clk_en}, (k > 0) ? {15'h0, k == 2, 16'h0} : {13'h7, 16'(~gate)});
      repeat (20) @(posedge hclk);
      chk(clk_en.core, 1'b0);
      irq_pending <= 1'b1;
      req <= 1'b0;
      @(posedge hclk);
      irq_pending <= 1'b0;
      cnt = 0;
      p = 0;
      repeat (200) begin
        @(posedge hclk);
        cnt += (clk_en.core !== 1'b1);
        p += (clk_en.pll === 1'b1 && clk_en.core !== 1'b1);
      end
      chk((k > 0) ? (p >= 16) : (cnt < 3), 1);
      chk({12'h0, clk_en}, {12'h0, 4'hf, 16'(~gate)});
      chk({uhc_suspend, udc_suspend}, (k == 2) ? 2'h3 : 2'h0);
    end
    $display("test idle and sleep done");
    // reserved sleep kind 2: sleep instruction must leave the mode alone
    wr(ADDR_LOW_POWER_CONTROL, 32'hfa);
    dly <= 4'(3 + $urandom % 6);
    req <= 1'b1;
    repeat (12) @(posedge hclk);
    rdck(ADDR_MODE_STATUS, {29'h0, MODE_NORMAL});
    chk(clk_en.core, 1'b1);
    req <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({30'h0, hreadyout, hresp}, 32'h2);
    $display("test reserved kind done");
    // mid-run reset: control and gate registers back to their reset values
    wr(ADDR_LOW_POWER_CONTROL, 32'h0d);
    wr(ADDR_MODULE_CLOCK_GATE, 32'h00ff);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({12'h0, clk_en}, 32'h000f_ffff);
    rdck(ADDR_LOW_POWER_CONTROL, 32'hf8);
    rdck(ADDR_MODULE_CLOCK_GATE, 32'h0);
    $display("test reset done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
